// file: rtl/seq_ctrl.sv
// Step controller shared by both channels of the waveform generator.
// Assumes inputs synchronous to core_clk and a step store loaded beforehand.
// Trigger routing for other modes is also decided here.

// Contract
// [R01] At most 255 steps per sequence
// [R02] Ten stored sequences kept for recall
// [R03] One step controller drives both channels
// [R04] Step time 0.1 ms to 1000 s
// [R05] Jump count 1..9999 or endless
// [R06] End phase 0..360 deg or disabled
// [R07] Parameters held, kept or linearly ramped
// [R08] State branch sampled at step end
// [R09] Event branch jumps immediately
// [R10] Step end stops or advances
// [R11] Four-bit step code driven per step
// [R12] Code LSB optionally on sync output
// [R13] After DC or noise, restart at 0 deg
// [R14] At most 128 waveforms referenced
// [R15] Start, stop, hold, resume, event branch
// [R16] Connector inputs control the sequencer
// [R17] Start trigger from channel 1 input
// [R18] No sequence while tracking active
// [R19] Channel 2 may share channel 1 trigger
// [R20] Polarity per use; tracking never off
// [R21] Manual key serves all but tracking; here it feeds only trig_ch1 and trig_ch2, not the sequence start
// [R22] Internal oscillators never feed tracking
// [R23] Hold freezes timer, resume continues
module seq_ctrl
  import seq_pkg::*;
#(
  parameter int ADDR_W = 12
)(
  input  wire logic                  core_clk,
  input  wire logic                  arst_n,
  input  wire logic                  seq_enable,
  input  wire logic [SEQ_SEL_W-1:0]  seq_select,
  input  wire logic [STEP_IDX_W-1:0] start_step,
  input  wire logic [STEP_IDX_W-1:0] last_step,
  input  wire logic                  cmd_start,
  input  wire logic                  cmd_stop,
  input  wire logic                  cmd_hold,
  input  wire logic                  cmd_resume,
  input  wire logic                  cmd_event,
  input  wire logic                  mio_start_branch,
  input  wire logic                  mio_stop,
  input  wire logic                  mio_hold_resume,
  input  wire logic                  mio_event,
  input  wire logic                  ext_trig_ch1,
  input  wire logic                  ext_trig_ch2,
  input  pol_t                       seq_trig_pol,
  input  pol_t                       sweep_trig_pol,
  input  pol_t                       fsk_trig_pol,
  input  pol_t                       track_trig_pol,
  input  wire logic                  ch2_share_trig,
  input  wire logic                  tracking_on,
  input  wire logic                  manual_key,
  input  wire logic                  int_osc_ch1,
  input  wire logic                  int_osc_ch2,
  input  wire logic                  use_int_ch1,
  input  wire logic                  use_int_ch2,
  input  wire logic [PHASE_W-1:0]    ch1_ref_phase,
  input  wire logic                  wr_en,
  input  wire logic [ADDR_W-1:0]     wr_addr,
  input  wire logic [REC_W-1:0]      wr_data,
  input  wire logic                  sync_lsb_sel,
  output logic      [CODE_W-1:0]     step_code,
  output logic                       sync_sub_output,
  output logic      [STEP_IDX_W-1:0] cur_step,
  output logic      [WAVE_W-1:0]     cur_wave,
  output interp_t                    cur_interp,
  output logic      [TIME_W-1:0]     step_elapsed,
  output logic      [TIME_W-1:0]     step_length,
  output logic                       freeze,
  output logic                       phase_reset,
  output logic                       seq_running,
  output logic                       seq_refused,
  output logic                       trig_ch1,
  output logic                       trig_ch2,
  output logic                       trig_track
);

  seq_state_t state;
  logic [ADDR_W-1:0] rd_addr;
  logic [REC_W-1:0]  rec;
  logic [TICK_W-1:0] tick_cnt;
  logic              tick;
  logic [JUMP_W-1:0] jump_left;
  logic              prev_dcn;
  logic              mio_hr_prev;
  logic              load_ok;
  logic              seq_fire, sw1_fire, sw2_fire, fsk_fire, trk_fire;
  logic              trig2_src;
  logic              step_end, at_phase, go_start, go_stop, do_event;
  logic              hold_req, resume_req, hr_edge;
  logic [STEP_IDX_W-1:0] next_step;

  // Record fields
  logic [CODE_W-1:0]     r_code;
  logic [WAVE_W-1:0]     r_wave;
  interp_t               r_interp;
  logic [JUMP_W-1:0]     r_jump;
  logic [STEP_IDX_W-1:0] r_jdest, r_sdest, r_edest;
  logic                  r_stop, r_phen;
  logic [PHASE_W-1:0]    r_phase;
  logic [TIME_W-1:0]     r_time;

  // ----------------------------------------------------------------------
  // Step store and record unpacking
  // ----------------------------------------------------------------------
  step_mem #(.ADDR_W(ADDR_W)) u_mem (
    .core_clk (core_clk),
    .wr_en    (wr_en),
    .wr_addr  (wr_addr),
    .wr_data  (wr_data),
    .rd_addr  (rd_addr),
    .rd_data  (rec)
  );

  assign {r_code, r_wave, r_interp, r_jump, r_jdest, r_sdest, r_edest,
          r_stop, r_phen, r_phase, r_time} = rec;

  // Record address: sequence base plus step; sequences hold 256 slots
  function automatic logic [ADDR_W-1:0] rec_addr(
    input logic [SEQ_SEL_W-1:0]  sq,
    input logic [STEP_IDX_W-1:0] st
  );
    rec_addr = ADDR_W'({sq, st});
  endfunction

  // Send a step index beyond last_step back to start_step
  function automatic logic [STEP_IDX_W-1:0] clamp_step(
    input logic [STEP_IDX_W-1:0] st
  );
    clamp_step = (st > last_step) ? start_step : st;
  endfunction

  // ----------------------------------------------------------------------
  // Trigger sources
  // ----------------------------------------------------------------------
  trig_edge u_seq_trig (.core_clk(core_clk), .arst_n(arst_n),
    .external_trigger_input(ext_trig_ch1), .pol(seq_trig_pol), .fire(seq_fire)); // R17
  trig_edge u_sw1 (.core_clk(core_clk), .arst_n(arst_n),
    .external_trigger_input(ext_trig_ch1), .pol(sweep_trig_pol), .fire(sw1_fire));
  trig_edge u_sw2 (.core_clk(core_clk), .arst_n(arst_n),
    .external_trigger_input(trig2_src), .pol(sweep_trig_pol), .fire(sw2_fire));
  trig_edge u_fsk (.core_clk(core_clk), .arst_n(arst_n),
    .external_trigger_input(ext_trig_ch1), .pol(fsk_trig_pol), .fire(fsk_fire));
  trig_edge u_trk (.core_clk(core_clk), .arst_n(arst_n),
    .external_trigger_input(ext_trig_ch1),
    .pol(track_trig_pol == POL_OFF ? POL_POS : track_trig_pol),
    .fire(trk_fire)); // R20

  // Channel 2 may reuse channel 1's input
  assign trig2_src = ch2_share_trig ? ext_trig_ch1 : ext_trig_ch2; // R19

  // Manual and internal sources feed channel triggers, never tracking
  assign trig_ch1 = (use_int_ch1 ? int_osc_ch1 : (sw1_fire | fsk_fire))
                  | manual_key; // R21 R22
  assign trig_ch2 = (use_int_ch2 ? int_osc_ch2 : sw2_fire)
                  | manual_key; // R21 R22
  assign trig_track = tracking_on & trk_fire; // R22

  // ----------------------------------------------------------------------
  // Control decode; connector lines merged with commands, hold/resume as one toggle line, start line also branches
  // ----------------------------------------------------------------------
  assign hr_edge    = mio_hold_resume & ~mio_hr_prev;
  assign hold_req   = cmd_hold | (hr_edge && state == ST_RUN); // R16
  assign resume_req = cmd_resume | (hr_edge && state == ST_HOLD); // R16
  assign go_stop    = cmd_stop | mio_stop; // R15 R16
  assign do_event   = (cmd_event | mio_event)
                    && (state == ST_RUN); // R09
  assign go_start   = (cmd_start | seq_fire | mio_start_branch)
                    && seq_enable && !tracking_on; // R17 R18
  assign seq_refused = seq_enable & tracking_on; // R18

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      mio_hr_prev <= 1'b0;
    else
      mio_hr_prev <= mio_hold_resume;
  end

  // ----------------------------------------------------------------------
  // 10 us time base; stalls while held
  // ----------------------------------------------------------------------
  assign tick = (tick_cnt == TICK_W'(TICK_CYC - 1));

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      tick_cnt <= '0;
    else if (state != ST_RUN)
      tick_cnt <= (state == ST_HOLD) ? tick_cnt : '0; // R23
    else if (tick)
      tick_cnt <= '0;
    else
      tick_cnt <= tick_cnt + 1'b1;
  end

  // ----------------------------------------------------------------------
  // Step end: time reached, then optional wait for channel 1 phase
  // ----------------------------------------------------------------------
  assign at_phase = !r_phen || (ch1_ref_phase == r_phase); // R06
  assign step_end = (state == ST_RUN) && tick
                 && (step_elapsed + 1'b1 >= step_length) && at_phase; // R04

  // Next step: state branch, jump, or advance wrapping to start_step
  always_comb
  begin
    if (mio_start_branch)
      next_step = clamp_step(r_sdest); // R08
    else if (r_jump == JUMP_INF || jump_left > 1)
      next_step = clamp_step(r_jdest); // R05
    else
      next_step = (cur_step >= last_step) ? start_step
                                          : cur_step + 1'b1; // R01
  end

  // ----------------------------------------------------------------------
  // Sequencer state and current step
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state    <= ST_IDLE;
      cur_step <= '0;
    end
    else if (go_stop || (state != ST_IDLE && tracking_on))
      state <= ST_IDLE; // R15 R18
    else
    begin
      unique case (state)
        ST_IDLE:
          if (go_start)
          begin
            cur_step <= start_step;
            state    <= ST_LOAD;
          end
        ST_LOAD:
          if (load_ok)
            state <= ST_RUN;
        ST_RUN:
          if (do_event)
          begin
            cur_step <= clamp_step(r_edest); // R09
            state    <= ST_LOAD;
          end
          else if (hold_req)
            state <= ST_HOLD; // R23
          else if (step_end && r_stop && !mio_start_branch)
            state <= ST_IDLE; // R10
          else if (step_end)
          begin
            cur_step <= next_step; // R10
            state    <= ST_LOAD;
          end
        ST_HOLD:
          if (resume_req)
            state <= ST_RUN; // R23
      endcase
    end
  end

  assign rd_addr = rec_addr(seq_select, cur_step); // R02

  // Store read is registered, so the first load cycle still shows the
  // previous record; the step is only taken up on the second cycle
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      load_ok <= 1'b0;
    else
      load_ok <= (state == ST_LOAD) && !load_ok;
  end

  // ----------------------------------------------------------------------
  // Step timer; frozen in hold, restarted on each load
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      step_elapsed <= '0;
      step_length  <= TIME_MIN;
    end
    else if (state == ST_LOAD)
    begin
      step_elapsed <= '0;
      step_length  <= (r_time < TIME_MIN) ? TIME_MIN
                    : (r_time > TIME_MAX) ? TIME_MAX : r_time; // R04
    end
    else if (state == ST_RUN && tick && step_elapsed < step_length)
      step_elapsed <= step_elapsed + 1'b1; // R23
  end

  // ----------------------------------------------------------------------
  // Jump counter; loaded at a step end while zero, cleared while idle
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      jump_left <= '0;
    else if (state == ST_IDLE)
      jump_left <= '0;
    else if (step_end && r_jump != JUMP_INF)
    begin
      if (jump_left == '0)
        jump_left <= (r_jump > JUMP_MAX) ? JUMP_MAX : r_jump; // R05
      else
        jump_left <= jump_left - 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs per step: code, waveform, interpolation, phase restart
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      step_code       <= '0;
      sync_sub_output <= 1'b0;
      cur_wave        <= '0;
      cur_interp      <= IP_CONST;
      phase_reset     <= 1'b0;
      prev_dcn        <= 1'b0;
    end
    else if (state == ST_LOAD && load_ok)
    begin
      step_code       <= r_code; // R11
      sync_sub_output <= sync_lsb_sel & r_code[0]; // R12
      cur_wave        <= r_wave; // R14
      cur_interp      <= (r_interp == IP_LINEAR && r_wave != cur_wave)
                         ? IP_CONST : r_interp; // R07
      phase_reset     <= prev_dcn; // R13
      prev_dcn        <= (r_wave == '0) || (r_wave == WAVE_W'(1));
    end
    else
    begin
      phase_reset <= 1'b0;
      if (state == ST_IDLE)
      begin
        step_code       <= '0;
        sync_sub_output <= 1'b0;
      end
    end
  end

  // Both channels read the same step state
  assign seq_running = (state != ST_IDLE); // R03
  assign freeze      = (state == ST_HOLD); // R23

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_refuse;
    @(posedge core_clk) disable iff (!arst_n)
    tracking_on |=> !seq_running;
  endproperty
  a_refuse: assert property (p_refuse) else $error("run while tracking"); // R18

  property p_hold;
    @(posedge core_clk) disable iff (!arst_n)
    (state == ST_HOLD) ##1 (state == ST_HOLD)
      |-> $stable(step_elapsed);
  endproperty
  a_hold: assert property (p_hold) else $error("timer moved in hold"); // R23

  property p_event;
    @(posedge core_clk) disable iff (!arst_n)
    (do_event && !go_stop && !tracking_on) |=> (state == ST_LOAD);
  endproperty
  a_event: assert property (p_event) else $error("event not taken"); // R09

  property p_code;
    @(posedge core_clk) disable iff (!arst_n)
    (state == ST_LOAD && load_ok && !go_stop && !tracking_on)
      |=> step_code == $past(r_code);
  endproperty
  a_code: assert property (p_code) else $error("step code wrong"); // R11

  property p_sync;
    @(posedge core_clk) disable iff (!arst_n)
    sync_sub_output |-> step_code[0];
  endproperty
  a_sync: assert property (p_sync) else $error("sync not code lsb"); // R12

  property p_len;
    @(posedge core_clk) disable iff (!arst_n)
    step_length >= TIME_MIN && step_length <= TIME_MAX;
  endproperty
  a_len: assert property (p_len) else $error("step length out of range"); // R04

  property p_step;
    @(posedge core_clk) disable iff (!arst_n)
    seq_running |-> cur_step <= last_step || cur_step == start_step;
  endproperty
  a_step: assert property (p_step) else $error("step beyond last"); // R01

  property p_track;
    @(posedge core_clk) disable iff (!arst_n)
    (manual_key && !trk_fire) |-> !trig_track;
  endproperty
  a_track: assert property (p_track) else $error("manual fed tracking"); // R21

endmodule

// file: rtl/seq_pkg.sv
// Package: constants and types for the waveform step sequencer.
// Assumes a single 10 MHz core clock; step times are in 10 us ticks, only the tick is given in cycles.
package seq_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int MAX_STEPS      = 255;
  localparam int STEP_IDX_W     = 8;
  localparam int NUM_SEQUENCES  = 10;
  localparam int SEQ_SEL_W      = 4;
  localparam int MAX_WAVEFORMS  = 128;
  localparam int WAVE_W         = 7;
  localparam int CODE_W         = 4;
  localparam int JUMP_W         = 14;
  localparam logic [JUMP_W-1:0] JUMP_MAX  = 14'h270F; // 9999
  localparam logic [JUMP_W-1:0] JUMP_INF  = 14'h0000; // Zero means endless
  localparam int TIME_W         = 27;                 // In 10 us ticks
  localparam logic [TIME_W-1:0] TIME_MIN  = 27'h000000A;   // 0.1 ms
  localparam logic [TIME_W-1:0] TIME_MAX  = 27'h5F5E100;   // 1000 s
  localparam int PHASE_W        = 19;
  localparam logic [PHASE_W-1:0] PHASE_FULL = 19'h57E40; // 360.000 deg

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ         = 10_000_000;
  localparam int TICK_NS        = 10_000;             // 0.01 ms resolution
  localparam int TICK_CYC       = TICK_NS / 100;      // 100 ns per clock
  localparam int TICK_W         = 7;

  // ----------------------------------------------------------------------
  // Step record layout: {code, wave, interp, jump, jdest, sdest, edest,
  //                      stop, phen, phase, time}
  // ----------------------------------------------------------------------
  localparam int REC_W = CODE_W + WAVE_W + 2 + JUMP_W + 3*STEP_IDX_W
                       + 1 + 1 + PHASE_W + TIME_W;

  // Trigger polarity selection
  typedef enum logic [1:0] {
    POL_OFF = 2'b00,
    POL_POS = 2'b01,
    POL_NEG = 2'b10
  } pol_t;

  // Intra-step parameter behaviour
  typedef enum logic [1:0] {
    IP_CONST = 2'b00,
    IP_KEEP  = 2'b01,
    IP_LINEAR = 2'b10
  } interp_t;

  // Sequencer states, Gray coded along idle-load-run-hold
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_RUN  = 2'b11,
    ST_HOLD = 2'b10
  } seq_state_t;

  localparam logic [1:0] WAVE_DC_NOISE_NONE = 2'b00;

endpackage

// file: rtl/step_mem.sv
// Step store: all sequences' step records, one memory port each side.
// Assumes the write port is loaded by the panel/remote logic before a run.
module step_mem
  import seq_pkg::*;
#(
  parameter int DEPTH = NUM_SEQUENCES * (MAX_STEPS + 1),
  parameter int ADDR_W = 12,
  parameter int DATA_W = REC_W
)(
  input  wire logic              core_clk,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0] rd_data
);

  logic [DATA_W-1:0] mem [DEPTH];

  // ----------------------------------------------------------------------
  // Storage with registered read; no reset so it maps onto block memory
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (wr_en && (int'(wr_addr) < DEPTH))
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

// file: rtl/trig_edge.sv
// Trigger polarity selector and edge detector for one trigger input.
// Assumes the input is already synchronous to core_clk.
module trig_edge
  import seq_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic external_trigger_input,
  input  pol_t      pol,
  output logic      fire
);

  logic prev;

  // ----------------------------------------------------------------------
  // Previous level
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      prev <= 1'b0;
    else
      prev <= external_trigger_input;
  end

  // Off never fires; selection picks the active edge
  always_comb
  begin
    unique case (pol)
      POL_POS: fire = external_trigger_input & ~prev;
      POL_NEG: fire = ~external_trigger_input & prev;
      default: fire = 1'b0;
    endcase
  end

endmodule

// file: testbench/ext_equipment.sv
// External equipment model: start trigger and connector control lines.
// Assumes the bench's core_clk; lines idle low except for a pulse call's one high cycle or while a level call holds them high.
module ext_equipment
(
  input  wire logic       core_clk,
  output logic      [4:0] lines
);
  timeunit 1ns;
  timeprecision 1ns;

  // Bit 0 trigger, 1 start/branch, 2 stop, 3 hold/resume, 4 event
  initial lines = 5'h00;

  // One-cycle pulse, moved just after an edge so sampling is clean
  task automatic pulse(input int idx);
    @(posedge core_clk);
    #10 lines[idx] = 1'b1;
    @(posedge core_clk);
    #10 lines[idx] = 1'b0;
  endtask

  // Level held until changed again
  task automatic level(input int idx, input logic v);
    @(posedge core_clk);
    #10 lines[idx] = v;
  endtask
endmodule

// file: testbench/waveform_sequence_step_controller_tb.sv
// Self-checking bench for the step controller of the sequencer.
// Assumes seq_ctrl and ext_equipment; steps are 10 ticks of 100 cycles.
module waveform_sequence_step_controller_tb;
  import seq_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic core_clk = 1'b0, arst_n = 1'b0, seq_enable = 1'b1;
  logic ch2_share_trig = 1'b0, tracking_on = 1'b0, manual_key = 1'b0;
  logic int_osc_ch1 = 1'b0, int_osc_ch2 = 1'b0, use_int_ch1 = 1'b0;
  logic use_int_ch2 = 1'b0, ext_trig_ch2 = 1'b0, sync_lsb_sel = 1'b1;
  logic wr_en = 1'b0;
  logic [SEQ_SEL_W-1:0] seq_select = 4'h0;
  logic [STEP_IDX_W-1:0] start_step = 8'h00, last_step = 8'h02;
  logic [PHASE_W-1:0] ch1_ref_phase = 19'h00000;
  logic [11:0] wr_addr = 12'h000;
  logic [REC_W-1:0] wr_data = '0;
  pol_t seq_trig_pol = POL_OFF, sweep_trig_pol = POL_POS;
  pol_t fsk_trig_pol = POL_POS, track_trig_pol = POL_POS;
  logic [4:0] cmds = 5'h00;
  logic [4:0] lines;
  wire logic cmd_start = cmds[0], cmd_stop = cmds[1], cmd_hold = cmds[2];
  wire logic cmd_resume = cmds[3], cmd_event = cmds[4];
  wire logic ext_trig_ch1 = lines[0], mio_start_branch = lines[1];
  wire logic mio_stop = lines[2], mio_hold_resume = lines[3];
  wire logic mio_event = lines[4];
  logic [CODE_W-1:0] step_code;
  logic [STEP_IDX_W-1:0] cur_step;
  logic [WAVE_W-1:0] cur_wave;
  interp_t cur_interp;
  logic [TIME_W-1:0] step_elapsed, step_length;
  logic sync_sub_output, freeze, phase_reset, seq_running, seq_refused;
  logic trig_ch1, trig_ch2, trig_track;
  int fail_count = 0, n_compared = 0, cycles = 0;

  seq_ctrl u_dut (.*);
  ext_equipment u_ext (.core_clk(core_clk), .lines(lines));

  // Clock and hang guard; the ceiling is several times the planned run
  initial forever #50 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic summarize;
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, got);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #10;
  endtask

  // Panel command pulse, one cycle wide
  task automatic cmd(input int idx);
    tick(1);
    cmds[idx] = 1'b1;
    tick(1);
    cmds[idx] = 1'b0;
  endtask

  // Minimum step time, no end phase, sine-like wave, one jump to jd
  task automatic load(input logic [7:0] s, input logic [3:0] c,
                      input logic [7:0] jd, sd, ed, input logic stp);
    tick(1);
    wr_en = 1'b1;
    wr_addr = {4'h0, s};
    wr_data = {c, 7'h02, 2'h0, 14'h0001, jd, sd, ed, stp, 1'b0,
               19'h00000, TIME_MIN};
    tick(1);
    wr_en = 1'b0;
  endtask

  task automatic wait_step(input logic [7:0] s, input int lim);
    int n;
    n = 0;
    while (!(cur_step === s && seq_running === 1'b1) && n < lim)
    begin
      tick(1);
      n++;
    end
    // Let the two-cycle step load finish before judging the outputs
    tick(3);
    check("cur_step", {24'h0, s}, {24'h0, cur_step});
    check("seq_running", 1, seq_running);
  endtask

  task automatic wait_idle(input int lim);
    int n;
    n = 0;
    while (seq_running !== 1'b0 && n < lim)
    begin
      tick(1);
      n++;
    end
    // Step outputs are cleared one cycle after the state goes idle
    tick(2);
    check("seq_running", 0, seq_running);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_run;
    cmd(0);
    wait_step(8'h00, 10);
    check("step_code", 4'h5, step_code);
    check("sync_sub_output", 1, sync_sub_output);
    check("step_length", TIME_MIN, step_length);
    check("cur_wave", 2, cur_wave);
    check("cur_interp", IP_CONST, cur_interp);
    check("phase_reset", 0, phase_reset);
    tick(900);
    check("early step", 0, cur_step);
    wait_step(8'h01, 600);
    check("step_code", 4'hA, step_code);
    check("sync_sub_output", 0, sync_sub_output);
    wait_step(8'h02, 1500);
    check("step_code", 4'h3, step_code);
    wait_idle(1500);
    check("idle step_code", 0, step_code);
  endtask

  task automatic t_hold;
    logic [TIME_W-1:0] e;
    cmd(0);
    wait_step(8'h00, 10);
    tick(300);
    cmd(2);
    tick(3);
    e = step_elapsed;
    check("freeze", 1, freeze);
    tick(400);
    check("held elapsed", e, step_elapsed);
    cmd(3);
    tick(200);
    check("elapsed moves", 1, step_elapsed > e);
    check("freeze", 0, freeze);
    cmd(4);
    wait_step(8'h02, 10);
    cmd(1);
    wait_idle(10);
  endtask

  task automatic t_ext;
    u_ext.level(1, 1'b1);
    wait_step(8'h00, 10);
    wait_step(8'h02, 1500);
    u_ext.level(1, 1'b0);
    u_ext.pulse(2);
    wait_idle(10);
    seq_trig_pol = POL_POS;
    u_ext.pulse(0);
    wait_step(8'h00, 10);
    u_ext.pulse(4);
    wait_step(8'h02, 10);
    u_ext.pulse(3);
    tick(3);
    check("freeze", 1, freeze);
    u_ext.pulse(3);
    tick(3);
    check("freeze", 0, freeze);
    cmd(1);
    wait_idle(10);
    seq_trig_pol = POL_NEG;
    u_ext.level(0, 1'b1);
    tick(5);
    check("rise ignored", 0, seq_running);
    u_ext.level(0, 1'b0);
    wait_step(8'h00, 10);
    cmd(1);
    wait_idle(10);
  endtask

  // Tracking active: a start request must be turned away
  task automatic t_refuse;
    tracking_on = 1'b1;
    cmd(0);
    tick(2);
    check("seq_refused", 1, seq_refused);
    check("seq_running", 0, seq_running);
    tracking_on = 1'b0;
  endtask

  // Trigger routing: manual and internal sources never reach tracking
  task automatic t_trig;
    tracking_on = 1'b1;
    manual_key = 1'b1;
    tick(0);
    check("trig_ch1", 1, trig_ch1);
    check("trig_ch2", 1, trig_ch2);
    check("trig_track", 0, trig_track);
    manual_key = 1'b0;
    use_int_ch1 = 1'b1;
    int_osc_ch1 = 1'b1;
    tick(0);
    check("trig_ch1", 1, trig_ch1);
    check("trig_track", 0, trig_track);
    use_int_ch1 = 1'b0;
    int_osc_ch1 = 1'b0;
    ch2_share_trig = 1'b1;
    u_ext.level(0, 1'b1);
    tick(0);
    check("trig_track", 1, trig_track);
    check("trig_ch2", 1, trig_ch2);
    // Tracking stays on past the falling edge so no start is taken
    u_ext.level(0, 1'b0);
    tick(2);
    tracking_on = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    tick(20);
    arst_n = 1'b1;
    check("reset code", 0, step_code);
    check("reset running", 0, seq_running);
    load(8'h00, 4'h5, 8'h01, 8'h02, 8'h02, 1'b0);
    load(8'h01, 4'hA, 8'h02, 8'h00, 8'h00, 1'b0);
    load(8'h02, 4'h3, 8'h00, 8'h00, 8'h00, 1'b1);
    t_run();
    t_hold();
    t_ext();
    t_refuse();
    t_trig();
    summarize();
  end
endmodule
